// File: rtl/dpw_map.vh
/*
 register offsets, field positions, reset values and timing counts
 for the dual pin waveform output block; included by every rtl file except the square wave generator
*/
`ifndef DPW_MAP_VH
`define DPW_MAP_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define DPW_REG_CTRL     12'h000
`define DPW_REG_PERIOD   12'h004
`define DPW_REG_DUTY0    12'h008
`define DPW_REG_DUTY1    12'h00c
`define DPW_REG_SQHALF0  12'h010
`define DPW_REG_SQHALF1  12'h014
`define DPW_REG_STATUS   12'h018
`define DPW_REG_COUNT    12'h01c

// ----------------------------------------------------------------
// control fields: per pin function select and enable
// ----------------------------------------------------------------
`define DPW_CTRL_EN0     0
`define DPW_CTRL_FN0     1
`define DPW_CTRL_EN1     2
`define DPW_CTRL_FN1     3
`define DPW_FN_PWM       1'b0
`define DPW_FN_SQUARE    1'b1

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define DPW_CTRL_RST     4'h0
`define DPW_PERIOD_RST   32'h0000_03e8
`define DPW_DUTY_RST     32'h0000_0000
`define DPW_SQHALF_RST   32'h0000_0000
`define DPW_REF_HZ       20000000
`define DPW_TICK_HZ      1000000
`define DPW_TICK_DIV     (`DPW_REF_HZ / `DPW_TICK_HZ)

`endif

// File: rtl/dpw_tick_gen.v
/*
 makes a one-cycle tick at the timer rate from ref_clk;
 assumes ref_clk is a whole multiple of the tick rate
*/
`include "dpw_map.vh"

module dpw_tick_gen
#(
    parameter DIV = `DPW_TICK_DIV
)
(
    input  wire ref_clk,
    input  wire nrst,
    output wire tick
);

    reg  [7:0] cnt_ff;
    wire [7:0] nxt_cnt;

    assign tick    = (cnt_ff == DIV[7:0] - 8'h01);
    assign nxt_cnt = tick ? 8'h00 : cnt_ff + 8'h01;

    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            cnt_ff <= 8'h00;
        else
            cnt_ff <= nxt_cnt;
    end

endmodule

// File: rtl/dpw_square_gen.v
/*
 square wave output of equal mark and space at half period counts
 of ref_clk; half count zero holds the output low (0 hz)
*/
module dpw_square_gen
(
    input  wire        ref_clk,
    input  wire        nrst,
    input  wire        enable,
    input  wire [31:0] half_cnt,
    output wire        wave
);

    reg  [31:0] cnt_ff;
    reg         wave_ff;
    wire        run;
    wire        flip;

    // fastest setting is half count 1 -> ref_clk / 2; 5 mhz needs 2 at
    // 20 mhz, so the top of the range is bounded by the clock rate
    assign run  = enable && (half_cnt != 32'h0000_0000);
    assign flip = run && (cnt_ff >= half_cnt - 32'h0000_0001);
    assign wave = wave_ff;

    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt_ff  <= 32'h0000_0000;
            wave_ff <= 1'b0;
        end
        else if (!run)
        begin
            cnt_ff  <= 32'h0000_0000;
            wave_ff <= 1'b0;
        end
        else if (flip)
        begin
            cnt_ff  <= 32'h0000_0000;
            wave_ff <= ~wave_ff;
        end
        else
            cnt_ff  <= cnt_ff + 32'h0000_0001;
    end

endmodule

// File: rtl/dpw_core.v
/*
 two pin pwm / square wave output block with apb register slave.
 assumes an apb master on ref_clk and 32-bit aligned word access.
*/
// The placing of the registers and register access over APB were left to the implementer.
`include "dpw_map.vh"

module dpw_core
(
    input  wire        ref_clk,
    input  wire        nrst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    output wire [1:0]  general_pin
);

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    reg  [3:0]  ctrl_ff;
    reg  [31:0] period_ff;
    reg  [31:0] duty0_ff;
    reg  [31:0] duty1_ff;
    reg  [31:0] sqhalf0_ff;
    reg  [31:0] sqhalf1_ff;
    reg  [31:0] prdata_ff;
    reg  [31:0] nxt_prdata;
    reg         hit;
    reg  [31:0] cnt_ff;
    reg  [1:0]  pwm_ff;
    reg  [1:0]  pin_ff;
    reg  [31:0] nxt_cnt;
    reg  [1:0]  nxt_pwm;
    reg  [1:0]  nxt_pin;
    wire        tick;
    wire [1:0]  sq_wave;
    wire        wr_en;
    wire        rd_en;
    wire [31:0] per_eff;

    // ----------------------------------------------------------------
    // decode shared by both pins
    // ----------------------------------------------------------------
    function is_square;
        input en;
        input fn;
        begin
            is_square = en && (fn == `DPW_FN_SQUARE);
        end
    endfunction

    // ----------------------------------------------------------------
    // apb slave: zero wait, unmapped or misaligned gives pslverr
    // ----------------------------------------------------------------
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign wr_en   = psel && penable && pwrite && hit;
    assign rd_en   = psel && !penable && !pwrite;
    assign prdata  = prdata_ff;

    always @*
    begin
        hit        = 1'b1;
        nxt_prdata = 32'h0000_0000;
        case (paddr)
            `DPW_REG_CTRL:    nxt_prdata = {28'h0000000, ctrl_ff};
            `DPW_REG_PERIOD:  nxt_prdata = period_ff;
            `DPW_REG_DUTY0:   nxt_prdata = duty0_ff;
            `DPW_REG_DUTY1:   nxt_prdata = duty1_ff;
            `DPW_REG_SQHALF0: nxt_prdata = sqhalf0_ff;
            `DPW_REG_SQHALF1: nxt_prdata = sqhalf1_ff;
            `DPW_REG_STATUS:  nxt_prdata = {30'h00000000, pin_ff};
            `DPW_REG_COUNT:   nxt_prdata = cnt_ff;
            default:          hit = 1'b0;
        endcase
    end

    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_ff    <= `DPW_CTRL_RST;
            period_ff  <= `DPW_PERIOD_RST;
            duty0_ff   <= `DPW_DUTY_RST;
            duty1_ff   <= `DPW_DUTY_RST;
            sqhalf0_ff <= `DPW_SQHALF_RST;
            sqhalf1_ff <= `DPW_SQHALF_RST;
            prdata_ff  <= 32'h0000_0000;
        end
        else
        begin
            // read data captured in setup so it is stable in access
            if (rd_en)
                prdata_ff <= nxt_prdata;
            if (wr_en)
            begin
                case (paddr)
                    `DPW_REG_CTRL:    ctrl_ff    <= pwdata[3:0];
                    `DPW_REG_PERIOD:  period_ff  <= pwdata;
                    `DPW_REG_DUTY0:   duty0_ff   <= pwdata;
                    `DPW_REG_DUTY1:   duty1_ff   <= pwdata;
                    `DPW_REG_SQHALF0: sqhalf0_ff <= pwdata;
                    `DPW_REG_SQHALF1: sqhalf1_ff <= pwdata;
                    default:          ctrl_ff    <= ctrl_ff;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // 1 mhz timer base
    // ----------------------------------------------------------------
    dpw_tick_gen u_tick
    (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .tick    (tick)
    );

    // ----------------------------------------------------------------
    // shared period counter and per pin compare
    // ----------------------------------------------------------------
    // a period below 1 is clamped to 1: the counter cannot beat the tick
    assign per_eff = (period_ff == 32'h0000_0000) ? 32'h0000_0001
                                                  : period_ff;

    always @*
    begin
        nxt_cnt = cnt_ff;
        if (tick)
            nxt_cnt = (cnt_ff >= per_eff - 32'h0000_0001)
                      ? 32'h0000_0000
                      : cnt_ff + 32'h0000_0001;
        // duty >= period stays high, duty 0 never high
        nxt_pwm[0] = (cnt_ff < duty0_ff);
        nxt_pwm[1] = (cnt_ff < duty1_ff);
    end

    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt_ff <= 32'h0000_0000;
            pwm_ff <= 2'b00;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            pwm_ff <= nxt_pwm;
        end
    end

    // ----------------------------------------------------------------
    // square wave sources
    // ----------------------------------------------------------------
    dpw_square_gen u_sq0
    (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .enable   (is_square(ctrl_ff[`DPW_CTRL_EN0],
                             ctrl_ff[`DPW_CTRL_FN0])),
        .half_cnt (sqhalf0_ff),
        .wave     (sq_wave[0])
    );

    dpw_square_gen u_sq1
    (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .enable   (is_square(ctrl_ff[`DPW_CTRL_EN1],
                             ctrl_ff[`DPW_CTRL_FN1])),
        .half_cnt (sqhalf1_ff),
        .wave     (sq_wave[1])
    );

    // ----------------------------------------------------------------
    // pin function select
    // ----------------------------------------------------------------
    always @*
    begin
        nxt_pin[0] = 1'b0;
        nxt_pin[1] = 1'b0;
        if (ctrl_ff[`DPW_CTRL_EN0])
            nxt_pin[0] = (ctrl_ff[`DPW_CTRL_FN0] == `DPW_FN_SQUARE)
                         ? sq_wave[0] : pwm_ff[0];
        if (ctrl_ff[`DPW_CTRL_EN1])
            nxt_pin[1] = (ctrl_ff[`DPW_CTRL_FN1] == `DPW_FN_SQUARE)
                         ? sq_wave[1] : pwm_ff[1];
    end

    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            pin_ff <= 2'b00;
        else
            pin_ff <= nxt_pin;
    end

    assign general_pin = pin_ff;

endmodule

// File: tb/dpw_core_asserts.sv
/*
 checker for dpw_core port behaviour, bound into every dpw_core.
 assumes one ref_clk domain and apb writes as the only config path.
*/
`include "dpw_map.vh"

module dpw_core_chk
(
    input wire logic        ref_clk,
    input wire logic        nrst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [1:0]  general_pin
);
timeunit 1ns;
timeprecision 1ns;
// ----------------------------------------------------------------
// shadow of the config, rebuilt from apb writes
// ----------------------------------------------------------------
logic [3:0]  ctl_ff;
logic [31:0] per_ff, d0_ff, d1_ff, sq0_ff;
logic [7:0]  age_ff, run_ff;
wire         wr = psel && penable && pwrite;
// age saturates so a stable config is recognised without a wide count
always @(posedge ref_clk or negedge nrst)
if (!nrst)
begin
    ctl_ff <= 4'h0;
    per_ff <= `DPW_PERIOD_RST;
    d0_ff  <= 32'h0;
    d1_ff  <= 32'h0;
    sq0_ff <= 32'h0;
    age_ff <= 8'h00;
    run_ff <= 8'h00;
end
else
begin
    run_ff <= general_pin[1] ? run_ff + 8'h01 : 8'h00;
    age_ff <= wr ? 8'h00 : (age_ff == 8'hff ? age_ff : age_ff + 8'h01);
    if (wr && paddr == `DPW_REG_CTRL) ctl_ff <= pwdata[3:0];
    if (wr && paddr == `DPW_REG_PERIOD) per_ff <= pwdata;
    if (wr && paddr == `DPW_REG_DUTY0) d0_ff <= pwdata;
    if (wr && paddr == `DPW_REG_DUTY1) d1_ff <= pwdata;
    if (wr && paddr == `DPW_REG_SQHALF0) sq0_ff <= pwdata;
end
// ----------------------------------------------------------------
// assertions
// ----------------------------------------------------------------
default clocking @(posedge ref_clk); endclocking
default disable iff (!nrst);
sequence s_sq_high;
    general_pin[0] ##1 general_pin[0] ##1 !general_pin[0];
endsequence
chk_ready_const: assert property (pready) else $error("pready low");
chk_err_unmapped: assert property (psel && penable && paddr >= 12'h020
    |-> pslverr && (pwrite || prdata == 32'h0)) else $error("bad miss");
chk_err_mapped: assert property (psel && penable && paddr < 12'h020
    && paddr[1:0] == 2'b00 |-> !pslverr) else $error("false slave error");
chk_pin0_off: assert property (!ctl_ff[0] [*3] |-> !general_pin[0])
    else $error("pin0 driven while off");
chk_pin1_off: assert property (!ctl_ff[2] [*3] |-> !general_pin[1])
    else $error("pin1 driven while off");
chk_duty_zero: assert property ((ctl_ff[1:0] == 2'b01 && d0_ff == 0) [*3]
    |-> !general_pin[0]) else $error("zero duty not low");
chk_duty_full: assert property ((ctl_ff[3:2] == 2'b01 && d1_ff != 0
    && d1_ff >= per_ff) [*3] |-> general_pin[1]) else $error("full duty");
chk_pwm_high: assert property ($fell(general_pin[1]) && age_ff > 8'd200
    && ctl_ff[3:2] == 2'b01 && d1_ff < per_ff
    |-> run_ff == d1_ff * `DPW_TICK_DIV)
    else $error("pwm high time wrong");
chk_square_half: assert property (ctl_ff[1:0] == 2'b11 && sq0_ff == 2
    && age_ff > 8'd200 && $rose(general_pin[0]) |-> s_sq_high)
    else $error("square half period wrong");
endmodule

bind dpw_core dpw_core_chk dpw_core_chk_i (.ref_clk(ref_clk), .nrst(nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .general_pin(general_pin));

// File: tb/test_dual_pin_pwm_square_wave_output_output.sv
/*
 self-checking bench for dpw_core: apb tasks and pin level counts.
 assumes a 20 mhz ref_clk and the one microsecond timer tick.
*/
`include "dpw_map.vh"

module test_dual_pin_pwm_square_wave_output_output;
timeunit 1ns;
timeprecision 1ns;
localparam int TK  = 20;
localparam int NW  = 10;
localparam int PER = 4;
logic        ref_clk, nrst, psel, penable, pwrite, pready, pslverr, perr;
logic [11:0] paddr;
logic [31:0] pwdata, prdata, q;
logic [1:0]  general_pin;
int          n_errors, compares, h0, h1;

dpw_core dpw_core_i (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .general_pin(general_pin));

initial
begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
end
// ----------------------------------------------------------------
// tasks
// ----------------------------------------------------------------
task print_verdict;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
        $display("ALL CHECKS OK");
    else
        $display("CHECKS NOT OK");
    $finish;
endtask
task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
        n_errors++;
        $display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
    end
endtask
// one idle edge first, so back to back calls never reassign in one step
task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
        @(posedge ref_clk);
        k++;
    end
    while (pready !== 1'b1 && k < 20);
    q = prdata;
    perr = pslverr;
    if (pready !== 1'b1)
    begin
        n_errors++;
        print_verdict;
    end
    psel <= 1'b0;
    penable <= 1'b0;
endtask
task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
endtask
// configure, let the waveform settle, then count high samples per pin
task run(input int p, input int d0, input int d1, input logic [31:0] c);
    apb(1'b1, `DPW_REG_PERIOD, p);
    apb(1'b1, `DPW_REG_DUTY0, d0);
    apb(1'b1, `DPW_REG_DUTY1, d1);
    apb(1'b1, `DPW_REG_CTRL, c);
    repeat (240) @(posedge ref_clk);
    h0 = 0;
    h1 = 0;
    repeat (NW * TK * PER)
    begin
        // pins are counted mid cycle, away from the edge that moves them
        @(negedge ref_clk);
        h0 += (general_pin[0] === 1'b1);
        h1 += (general_pin[1] === 1'b1);
    end
endtask
// ----------------------------------------------------------------
// main sequence
// ----------------------------------------------------------------
initial
begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    n_errors = 0;
    compares = 0;
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    chk(general_pin, 2'b00);
    rd(`DPW_REG_CTRL, `DPW_CTRL_RST);
    rd(`DPW_REG_PERIOD, `DPW_PERIOD_RST);
    rd(`DPW_REG_DUTY1, `DPW_DUTY_RST);
    rd(12'h020, 32'h0);
    chk(perr, 1'b1);
    apb(1'b1, `DPW_REG_PERIOD, 32'hffff_fffe);
    rd(`DPW_REG_PERIOD, 32'hffff_fffe);
    run(PER, 1, 3, 32'h5);
    chk(h0, NW * TK);
    chk(h1, NW * TK * 3);
    run(PER, 0, 5, 32'h5);
    chk(h0, 0);
    chk(h1, NW * TK * PER);
    apb(1'b1, `DPW_REG_SQHALF0, 32'h2);
    apb(1'b1, `DPW_REG_SQHALF1, 32'h0);
    run(PER, 0, 5, 32'hf);
    chk(h0, NW * TK * PER / 2);
    chk(h1, 0);
    run(PER, 1, 3, 32'h7);
    chk(h0, NW * TK * PER / 2);
    chk(h1, NW * TK * 3);
    // reset again while both pins run
    @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    chk(general_pin, 2'b00);
    rd(`DPW_REG_COUNT, 32'h0);
    rd(`DPW_REG_PERIOD, `DPW_PERIOD_RST);
    rd(`DPW_REG_SQHALF0, `DPW_SQHALF_RST);
    run(PER, 1, 3, 32'h0);
    chk(h0 + h1, 0);
    rd(`DPW_REG_STATUS, 32'h0);
    print_verdict;
end
endmodule
